// >>> rtl/shunt_adc_filter_calibration.sv
// Digital part of one current-shunt ADC channel: switch decode, sinc3
// decimator, offset/gain correction and a Wishbone register port.
// Assumes the modulator bit arrives synchronous to clk_i on mod_clk_o highs.
//
// Notes on behaviour
// - Input select code drives switches per table; all other switches open.
// - Code 10b shorts channel inputs internally for offset self-calibration.
// - Two-bit gain field picks amplifier gain 4, 8, 16 or 32.
// - Modulator clock is the main clock divided by two.
// - Bitstream decimated by third-order sinc filter by the oversampling ratio.
// - Three-bit ratio field selects powers of two from 64 to 8192.
// - Offset subtracted first, then multiplied by gain correction factor.
// - Scaled result rounded to output resolution and saturated at full scale.
// - Offset is 24-bit two's complement split over upper and lower registers.
// - One offset code equals one output code, subtracted.
// - Gain code adds one part in 65536 to a unity factor.
// - Results are two's complement, saturating at 800000h negative.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module shunt_adc_filter_calibration
    import shunt_adc_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Modulator link.
    input  wire logic        mod_bit_i,
    output logic             mod_clk_o,
    // Analog front-end controls.
    output logic             direct_input_switch_o,
    output logic             ground_short_switch_o,
    output logic             pga_positive_path_switch_o,
    output logic             pga_inverting_path_switch_o,
    output logic             test_source_switch_o,
    output logic [5:0]       pga_gain_o
);
    import shunt_adc_pkg::*;

    // ========================================================================
    // Helper functions.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [13:0] osr_of(input logic [2:0] sel);
        return 14'h0040 << sel;
    endfunction

    // Maps the sinc3 output (0..OSR^3) onto signed codes with 2^23 = full scale.
    function automatic logic signed [41:0] scale_raw(input logic [ACC_W-1:0] c,
                                                     input logic [2:0]       sel);
        logic signed [41:0] v;
        logic [5:0]         e;
        e = 6'(3 * (OSR_EXP_MIN + 6'(sel)));
        v = $signed({1'b0, c, 1'b0}) - $signed(42'h1 << e);
        if (e > RES_EXP) begin
            scale_raw = v >>> (e - RES_EXP);
        end else begin
            scale_raw = v <<< (RES_EXP - e);
        end
    endfunction

    // ========================================================================
    // Register file and bus state.
    wb_state_e         wb_reg, wb_next;
    logic              ack_next;
    logic [31:0]       dat_next;
    logic [1:0]        mux_reg, mux_next;
    logic [1:0]        gain_reg, gain_next;
    logic [2:0]        osr_reg, osr_next;
    logic [23:0]       ocal_reg, ocal_next;
    logic [15:0]       gcal_reg, gcal_next;
    logic              overrun_reg, overrun_next;
    logic              restart;
    logic              pop_req;
    logic [31:0]       ctrl_word, merged;

    sample_stream_if #(.WIDTH(RES_W)) fill_s ();
    sample_stream_if #(.WIDTH(RES_W)) drain_s ();

    // Filter state.
    logic              ph_reg;
    logic              tick;
    logic [12:0]       dec_cnt_reg, dec_cnt_next;
    logic              dec_tick;
    logic [ACC_W-1:0]  i1_reg, i2_reg, i3_reg, i1_next, i2_next, i3_next;
    logic [ACC_W-1:0]  d1_reg, d2_reg, d3_reg, d1_next, d2_next, d3_next;
    logic [ACC_W-1:0]  c3_reg, c3_next;
    logic [1:0]        settle_reg, settle_next;
    logic              calc_reg, calc_next;

    // Correction datapath.
    logic signed [41:0] raw;
    logic signed [25:0] diff;
    logic signed [17:0] gfac;
    logic signed [43:0] prod, rnd;
    logic [23:0]        res_reg, res_next;
    logic               res_vld_reg, res_vld_next;

    // Front-end outputs.
    logic [4:0]        sw_next;
    logic [5:0]        gain_o_next;

    assign ctrl_word = {25'h0, osr_reg, gain_reg, mux_reg};

    // ========================================================================
    // Wishbone slave: one-cycle answer, unmapped reads return zero.
    always_comb begin
        wb_next      = wb_reg;
        ack_next     = 1'b0;
        dat_next     = dat_o;
        mux_next     = mux_reg;
        gain_next    = gain_reg;
        osr_next     = osr_reg;
        ocal_next    = ocal_reg;
        gcal_next    = gcal_reg;
        restart      = 1'b0;
        pop_req      = 1'b0;
        overrun_next = overrun_reg;
        merged       = '0;
        case (wb_reg)
            WB_IDLE: begin
                if (cyc_i && stb_i) begin
                    wb_next  = WB_ACK;
                    ack_next = 1'b1;
                    dat_next = '0;
                    if (we_i) begin
                        case (adr_i)
                            CTRL_ADDR: begin
                                merged    = merge(ctrl_word, dat_i, sel_i);
                                mux_next  = merged[MUX_LSB +: 2];
                                gain_next = merged[GAIN_LSB +: 2];
                                osr_next  = merged[OSR_LSB +: 3];
                                restart   = 1'b1;
                            end
                            OCAL_MSB_ADDR: begin
                                merged    = merge({24'h0, ocal_reg[23:16]}, dat_i, sel_i);
                                ocal_next = {merged[7:0], ocal_reg[15:0]};
                            end
                            OCAL_LSB_ADDR: begin
                                merged    = merge({16'h0, ocal_reg[15:0]}, dat_i, sel_i);
                                ocal_next = {ocal_reg[23:16], merged[15:0]};
                            end
                            GCAL_ADDR: begin
                                merged    = merge({16'h0, gcal_reg}, dat_i, sel_i);
                                gcal_next = merged[15:0];
                            end
                            STATUS_ADDR: begin
                                if (sel_i[0] && dat_i[ST_OVERRUN_BIT]) begin
                                    overrun_next = 1'b0;
                                end
                            end
                            default: begin
                                merged = '0;
                            end
                        endcase
                    end else begin
                        case (adr_i)
                            CTRL_ADDR:     dat_next = ctrl_word;
                            OCAL_MSB_ADDR: dat_next = {24'h0, ocal_reg[23:16]};
                            OCAL_LSB_ADDR: dat_next = {16'h0, ocal_reg[15:0]};
                            GCAL_ADDR:     dat_next = {16'h0, gcal_reg};
                            STATUS_ADDR: begin
                                dat_next[ST_AVAIL_BIT]   = drain_s.valid;
                                dat_next[ST_OVERRUN_BIT] = overrun_reg;
                                dat_next[ST_SETTLED_BIT] = (settle_reg == SETTLE_OUTS);
                            end
                            DATA_ADDR: begin
                                dat_next[RES_W-1:0]     = drain_s.data;
                                dat_next[DATA_VALID_BIT] = drain_s.valid;
                                pop_req                  = drain_s.valid;
                            end
                            default:       dat_next = '0;
                        endcase
                    end
                end
            end
            WB_ACK: begin
                wb_next = WB_IDLE;
            end
            default: begin
                wb_next = WB_IDLE;
            end
        endcase
        // A lost sample sets the flag even in the cycle software clears it.
        if (dec_tick && res_vld_reg && !fill_s.ready) begin
            overrun_next = 1'b1;
        end
    end

    assign drain_s.ready = pop_req;

    // ========================================================================
    // Front-end decode.
    always_comb begin
        case (mux_reg)
            MUX_DIRECT:   sw_next = 5'b10100;
            MUX_INVERTED: sw_next = 5'b10010;
            MUX_SHORT:    sw_next = 5'b01100;
            MUX_TEST:     sw_next = 5'b00101;
            default:      sw_next = 5'b00000;
        endcase
        gain_o_next = 6'h04 << gain_reg;
    end

    // ========================================================================
    // Modulator clock and sinc3 decimator.
    always_comb begin
        tick     = ph_reg;
        dec_tick = tick && (dec_cnt_reg == 13'(osr_of(osr_reg) - 14'h1));
        dec_cnt_next = dec_cnt_reg;
        i1_next = i1_reg;
        i2_next = i2_reg;
        i3_next = i3_reg;
        d1_next = d1_reg;
        d2_next = d2_reg;
        d3_next = d3_reg;
        c3_next = c3_reg;
        settle_next = settle_reg;
        calc_next = 1'b0;
        if (tick) begin
            dec_cnt_next = dec_tick ? '0 : dec_cnt_reg + 13'h1;
            i1_next = i1_reg + ACC_W'(mod_bit_i);
            i2_next = i2_reg + i1_reg;
            i3_next = i3_reg + i2_reg;
        end
        if (dec_tick) begin
            d1_next = i3_reg;
            d2_next = i3_reg - d1_reg;
            d3_next = i3_reg - d1_reg - d2_reg;
            c3_next = i3_reg - d1_reg - d2_reg - d3_reg;
            calc_next = (settle_reg == SETTLE_OUTS);
            if (settle_reg != SETTLE_OUTS) begin
                settle_next = settle_reg + 2'h1;
            end
        end
        if (restart) begin
            dec_cnt_next = '0;
            settle_next  = '0;
            calc_next    = 1'b0;
        end
    end

    // ========================================================================
    // Offset then gain correction, rounding and clipping.
    always_comb begin
        raw  = scale_raw(c3_reg, osr_reg);
        diff = 26'(signed'(raw[24:0])) - 26'(signed'(ocal_reg));
        gfac = GAIN_UNITY + 18'(signed'(gcal_reg));
        prod = 44'(diff) * 44'(gfac);
        rnd  = (prod + ROUND_HALF) >>> GAIN_FRAC;
        res_next     = res_reg;
        res_vld_next = res_vld_reg && !fill_s.ready;
        if (calc_reg && !res_vld_next) begin
            res_vld_next = 1'b1;
            if (rnd > 44'(signed'(POS_FS))) begin
                res_next = POS_FS;
            end else if (rnd < 44'(signed'(NEG_FS))) begin
                res_next = NEG_FS;
            end else begin
                res_next = rnd[23:0];
            end
        end
    end

    assign fill_s.data  = res_reg;
    assign fill_s.valid = res_vld_reg;

    sample_fifo #(
        .WIDTH (RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .in_s  (fill_s),
        .out_s (drain_s)
    );

    // ========================================================================
    // State registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_reg      <= WB_IDLE;
            ack_o       <= 1'b0;
            dat_o       <= '0;
            mux_reg     <= MUX_RESET;
            gain_reg    <= GAIN_RESET;
            osr_reg     <= OSR_RESET;
            ocal_reg    <= '0;
            gcal_reg    <= '0;
            overrun_reg <= 1'b0;
            ph_reg      <= 1'b0;
            mod_clk_o   <= 1'b0;
            dec_cnt_reg <= '0;
            i1_reg      <= '0;
            i2_reg      <= '0;
            i3_reg      <= '0;
            d1_reg      <= '0;
            d2_reg      <= '0;
            d3_reg      <= '0;
            c3_reg      <= '0;
            settle_reg  <= '0;
            calc_reg    <= 1'b0;
            res_reg     <= '0;
            res_vld_reg <= 1'b0;
            {direct_input_switch_o, ground_short_switch_o, pga_positive_path_switch_o,
             pga_inverting_path_switch_o, test_source_switch_o} <= 5'b10100;
            pga_gain_o  <= 6'h04;
        end else begin
            wb_reg      <= wb_next;
            ack_o       <= ack_next;
            dat_o       <= dat_next;
            mux_reg     <= mux_next;
            gain_reg    <= gain_next;
            osr_reg     <= osr_next;
            ocal_reg    <= ocal_next;
            gcal_reg    <= gcal_next;
            overrun_reg <= overrun_next;
            ph_reg      <= !ph_reg;
            mod_clk_o   <= !ph_reg;
            dec_cnt_reg <= dec_cnt_next;
            i1_reg      <= i1_next;
            i2_reg      <= i2_next;
            i3_reg      <= i3_next;
            d1_reg      <= d1_next;
            d2_reg      <= d2_next;
            d3_reg      <= d3_next;
            c3_reg      <= c3_next;
            settle_reg  <= settle_next;
            calc_reg    <= calc_next;
            res_reg     <= res_next;
            res_vld_reg <= res_vld_next;
            {direct_input_switch_o, ground_short_switch_o, pga_positive_path_switch_o,
             pga_inverting_path_switch_o, test_source_switch_o} <= sw_next;
            pga_gain_o  <= gain_o_next;
        end
    end

    // ========================================================================
    // Checks.
    property p_short_switches;
        @(posedge clk_i) disable iff (rst_i)
        (mux_reg == MUX_SHORT) |=> ground_short_switch_o && !direct_input_switch_o
            && pga_positive_path_switch_o && !test_source_switch_o;
    endproperty
    a_short_switches: assert property (p_short_switches) else $error("short code bad");

    property p_invert_switches;
        @(posedge clk_i) disable iff (rst_i)
        (mux_reg == MUX_INVERTED) |=> direct_input_switch_o && pga_inverting_path_switch_o
            && !pga_positive_path_switch_o && !ground_short_switch_o;
    endproperty
    a_invert_switches: assert property (p_invert_switches) else $error("invert code bad");

    property p_gain_top;
        @(posedge clk_i) disable iff (rst_i)
        (gain_reg == 2'h3) |=> (pga_gain_o == 6'h20);
    endproperty
    a_gain_top: assert property (p_gain_top) else $error("gain 32 not driven");

    property p_mod_clock;
        @(posedge clk_i) disable iff (rst_i)
        mod_clk_o |=> !mod_clk_o ##1 mod_clk_o;
    endproperty
    a_mod_clock: assert property (p_mod_clock) else $error("modulator clock not half rate");

    property p_dec_spacing;
        @(posedge clk_i) disable iff (rst_i)
        dec_tick |=> !dec_tick [*8];
    endproperty
    a_dec_spacing: assert property (p_dec_spacing) else $error("decimation too fast");

    property p_pos_clip;
        @(posedge clk_i) disable iff (rst_i)
        (calc_reg && !res_vld_reg && rnd > 44'sh7FFFFF) |=> (res_reg == POS_FS);
    endproperty
    a_pos_clip: assert property (p_pos_clip) else $error("positive clip missing");

    property p_neg_clip;
        @(posedge clk_i) disable iff (rst_i)
        (calc_reg && !res_vld_reg && rnd < -44'sh800000) |=> (res_reg == NEG_FS);
    endproperty
    a_neg_clip: assert property (p_neg_clip) else $error("negative clip missing");

    property p_offset_only;
        @(posedge clk_i) disable iff (rst_i)
        (calc_reg && !res_vld_reg && gcal_reg == 16'h0 && raw < 42'sh400000
            && raw > -42'sh400000 && ocal_reg == 24'h000010)
        |=> (res_reg == 24'($past(raw) - 42'sh10));
    endproperty
    a_offset_only: assert property (p_offset_only) else $error("offset step wrong");

    property p_overrun_sets;
        @(posedge clk_i) disable iff (rst_i)
        (dec_tick && res_vld_reg && !fill_s.ready) |=> overrun_reg;
    endproperty
    a_overrun_sets: assert property (p_overrun_sets) else $error("overrun lost");
endmodule
`default_nettype wire

// >>> rtl/shunt_adc_pkg.sv
// Constants shared by the shunt ADC filter and calibration channel.
// Assumes a 250 MHz main clock and a classic Wishbone register port.
package shunt_adc_pkg;

    // ========================================================================
    // Register map (byte addresses, word aligned).
    localparam logic [7:0] CTRL_ADDR      = 8'h00;
    localparam logic [7:0] OCAL_MSB_ADDR  = 8'h04;
    localparam logic [7:0] OCAL_LSB_ADDR  = 8'h08;
    localparam logic [7:0] GCAL_ADDR      = 8'h0C;
    localparam logic [7:0] STATUS_ADDR    = 8'h10;
    localparam logic [7:0] DATA_ADDR      = 8'h14;

    // ========================================================================
    // Control register fields.
    localparam int         MUX_LSB        = 0;
    localparam int         GAIN_LSB       = 2;
    localparam int         OSR_LSB        = 4;
    localparam logic [1:0] MUX_RESET      = 2'h0;
    localparam logic [1:0] GAIN_RESET     = 2'h0;
    localparam logic [2:0] OSR_RESET      = 3'h0;

    // ========================================================================
    // Status and data fields.
    localparam int         ST_AVAIL_BIT   = 0;
    localparam int         ST_OVERRUN_BIT = 1;
    localparam int         ST_SETTLED_BIT = 2;
    localparam int         DATA_VALID_BIT = 31;

    // ========================================================================
    // Input multiplexer codes.
    localparam logic [1:0] MUX_DIRECT     = 2'h0;
    localparam logic [1:0] MUX_INVERTED   = 2'h1;
    localparam logic [1:0] MUX_SHORT      = 2'h2;
    localparam logic [1:0] MUX_TEST       = 2'h3;

    // ========================================================================
    // Filter and datapath.
    localparam int                ACC_W       = 40;
    localparam int                RES_W       = 24;
    localparam int                FIFO_DEPTH  = 4;
    localparam logic [5:0]        OSR_EXP_MIN = 6'h06;
    localparam logic [5:0]        RES_EXP     = 6'h17;
    localparam logic [1:0]        SETTLE_OUTS = 2'h3;
    localparam logic [23:0]       POS_FS      = 24'h7FFFFF;
    localparam logic [23:0]       NEG_FS      = 24'h800000;
    localparam logic signed [17:0] GAIN_UNITY = 18'sh10000;
    localparam logic signed [43:0] ROUND_HALF = 44'sh8000;
    localparam int                GAIN_FRAC   = 16;

    typedef enum logic [1:0] {
        WB_IDLE = 2'b00,
        WB_ACK  = 2'b01
    } wb_state_e;

endpackage

// >>> rtl/sample_stream_if.sv
// Valid/ready stream carrying corrected samples between internal modules.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface sample_stream_if #(parameter int WIDTH = 24);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> rtl/sample_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Stream ports.
    sample_stream_if.snk    in_s,
    sample_stream_if.src    out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign in_s.ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_reg != '0);
    assign out_s.data  = mem_reg[rd_reg];

    always_comb begin
        push     = in_s.valid && in_s.ready;
        pop      = out_s.valid && out_s.ready;
        wr_next  = push ? ((wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? ((rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1) : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
        if (push) begin
            mem_reg[wr_reg] <= in_s.data;
        end
    end
endmodule
`default_nettype wire

// >>> verification/mod_source.sv
// Stand-in for the channel's delta-sigma modulator bitstream.
// Assumes it shares the main clock and follows the divided modulator clock.
`timescale 1ns/100ps
`default_nettype none
module mod_source (
    // Clock and level select.
    input  wire logic       clk_i,
    input  wire logic       mod_clk_i,
    input  wire logic [1:0] level_i,
    // Bitstream.
    output logic            mod_bit_o
);
    // ========================================================================
    // The bit moves only on modulator-clock highs, so it stands two clocks.
    logic bit_q = 1'b0;
    assign mod_bit_o = bit_q;
    always @(posedge clk_i) begin
        if (mod_clk_i) begin
            bit_q <= level_i[1] ? ~bit_q : level_i[0];
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the shunt ADC channel.
// Assumes the Wishbone map and one-cycle ack given with the design.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import shunt_adc_pkg::*;
    // ========================================================================
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, mclk, mbit;
    logic [7:0] adr = 0;
    logic [31:0] wd = 0, rd, q;
    logic [1:0] lvl = 0;
    logic [4:0] sw;
    logic [5:0] gain;
    logic [4:0] sw_tab [4] = '{5'b10100, 5'b10010, 5'b01100, 5'b00101};
    int n_errors = 0, checks_done = 0, n;
    logic ack;
    initial forever #2 clk = ~clk;
    shunt_adc_filter_calibration shunt_adc_filter_calibration_inst (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(wd), .dat_o(rd), .ack_o(ack), .mod_bit_i(mbit),
        .mod_clk_o(mclk), .direct_input_switch_o(sw[4]), .ground_short_switch_o(sw[3]),
        .pga_positive_path_switch_o(sw[2]), .pga_inverting_path_switch_o(sw[1]),
        .test_source_switch_o(sw[0]), .pga_gain_o(gain));
    mod_source mod_source_inst (.clk_i(clk), .mod_clk_i(mclk), .level_i(lvl), .mod_bit_o(mbit));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
        do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
        q = rd;
        cyc <= 0; stb <= 0; we <= 0;
        if (k >= 50) n_errors++;
    endtask
    // Offset subtracted first, then unity-plus-code gain, round half up, clip.
    function automatic logic [23:0] model(int raw, logic signed [23:0] oc, logic signed [15:0] g);
        longint p;
        p = ((longint'(raw) - oc) * (65536 + g) + 32768) >>> 16;
        if (p > 8388607) p = 8388607;
        if (p < -8388608) p = -8388608;
        return p[23:0];
    endfunction
    task run(input logic [1:0] l, input logic [23:0] oc, input logic [15:0] g, input int raw,
             input logic [2:0] os);
        int m;
        m = 8 * (64 << os);
        lvl <= l;
        wb(1, OCAL_MSB_ADDR, {24'h0, oc[23:16]});
        wb(1, OCAL_LSB_ADDR, {16'h0, oc[15:0]});
        wb(1, GCAL_ADDR, {16'h0, g});
        wb(1, CTRL_ADDR, {25'h0, os, 4'h2});
        n = 0;
        do begin wb(0, DATA_ADDR, 0); n++; end while (q[31] === 1'b1);
        do begin wb(0, DATA_ADDR, 0); n++; end while (q[31] !== 1'b1 && n < 400);
        chk("sample", {8'h80, model(raw, oc, g)}, {q[31], 7'h0, q[23:0]});
        chk("rate", 32'h1, {31'h0, 3 * n >= m && 3 * n <= m + 6});
    endtask
    task close_out;
        if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        close_out;
    end
    initial begin
        void'($urandom(80069));
        repeat (5) @(posedge clk);
        rst <= 0;
        chk("reset", {21'h0, 5'b10100, 6'h04}, {21'h0, sw, gain});
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            q = mclk;
            @(posedge clk);
            chk("modclk", {31'h0, ~q[0]}, {31'h0, mclk});
            wb(1, CTRL_ADDR, {28'h0, 2'(3 - i), 2'(i)});
            repeat (3) @(posedge clk);
            chk("switch", {27'h0, sw_tab[i]}, {27'h0, sw});
            chk("gain", 32'd4 << (3 - i), {26'h0, gain});
        end
        run(2'd0, 24'h0, 16'h0, -8388608, 3'd0);
        run(2'd0, 24'hFFFFF0, 16'h0, -8388608, 3'd0);
        run(2'd0, 24'hFFFFF0, 16'h8000, -8388608, 3'd0);
        run(2'd0, 24'h0, 16'h7FFF, -8388608, 3'd0);
        run(2'd1, 24'h0, 16'h7FFF, 8388608, 3'd0);
        run(2'd2, 24'h0, 16'h0, 0, 3'd0);
        run(2'd2, 24'h000010, 16'h0, 0, 3'd0);
        run(2'd2, 24'hF00000, 16'h199A, 0, 3'd1);
        for (int i = 0; i < 3; i++) run(2'd0, 24'($urandom), 16'($urandom), -8388608, 3'd0);
        repeat (1000) @(posedge clk);
        wb(0, STATUS_ADDR, 0);
        chk("status", 32'h7, {29'h0, q[2:0]});
        repeat (5) wb(0, DATA_ADDR, 0);
        wb(1, STATUS_ADDR, 32'h2);
        wb(0, STATUS_ADDR, 0);
        chk("cleared", 32'h2, {30'h0, q[2:1]});
        close_out;
    end
endmodule
`default_nettype wire
